// file: heat_status_params.svh
// heat_status_params.svh: offsets, field positions, reset values and limits
// assumes inclusion by bare name from the heat status design files
`ifndef HEAT_STATUS_PARAMS_SVH
`define HEAT_STATUS_PARAMS_SVH

// register byte offsets
`define OFF_SETPOINT    8'h00
`define OFF_CONFIG      8'h04
`define OFF_STATUS      8'h08
`define OFF_ACTUAL      8'h0C
`define OFF_ERROR       8'h10
`define OFF_PARAM_SET   8'h14
`define OFF_PARAM_GET   8'h18
`define OFF_PARAM_DATA  8'h1C

// config fields
`define CFG_RANGE_BIT   0
`define CFG_MODE_LO     1
`define CFG_MODE_HI     2
`define OK_MODE_OFF     2'h0
`define OK_MODE_FOLLOW  2'h1
`define OK_MODE_LATCH   2'h2

// status word bit positions
`define ST_CAL_RUN      0
`define ST_CAL_BLOCK    1
`define ST_ALARM        2
`define ST_WARN         3
`define ST_REACHED      4
`define ST_IN_BAND      5
`define ST_CTRL_ACT     6
`define ST_INFO         7
`define ST_STANDBY      8
`define ST_GAP          9

// parameter command fields and instances
`define PAR_INST_HI     31
`define PAR_INST_LO     24
`define PAR_ATTR_HI     23
`define PAR_ATTR_LO     16
`define PAR_ATTR_VALUE  8'h01
`define PAR_INST_RANGE  8'h01
`define PAR_INST_TOL_LO 8'h02
`define PAR_INST_TOL_HI 8'h03
`define PAR_REJECT_BIT  16

// limits and reset values
`define SP_MAX_LOW      16'h012C
`define SP_MAX_HIGH     16'h01F4
`define TOL_MAX         16'h0063
`define TOL_DEFAULT     16'h000A
`define RANGE_DEFAULT   16'h000A
`define TE_SCALE        26'sh064
`define TE_THRESH       26'sh05F

`endif

// file: heat_status_pkg.sv
// heat_status_pkg: types shared by the heat status design files
// assumes nothing beyond a SystemVerilog compiler
package heat_status_pkg;
    // latching temperature-ok sequence
    typedef enum logic [1:0] {LATCH_IDLE, LATCH_WAIT, LATCH_IN, LATCH_OUT} latch_state_t;
    typedef logic [15:0] param_word_t;
endpackage : heat_status_pkg

// file: param_if.sv
// param_if: write and read path between status block and parameter store
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface param_if #(parameter int AW = 4);
    logic                      we;
    logic [AW-1:0]             waddr;
    heat_status_pkg::param_word_t wdata;
    logic                      re;
    logic [AW-1:0]             raddr;
    heat_status_pkg::param_word_t rdata;
    modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
    modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface : param_if
`default_nettype wire

// file: param_store.sv
// param_store: attribute-1 values of the parameter object instances
// assumes writes already vetted by the status block; read data registered
`timescale 1ns/1ns
`default_nettype none
`include "heat_status_params.svh"
module param_store #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    // parameter path
    param_if.mem      pif
);
    heat_status_pkg::param_word_t mem_reg [DEPTH];

    // storage, factory values at reset
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (i == 2 || i == 3) begin
                    mem_reg[i] <= `TOL_DEFAULT;
                end else if (i == 1) begin
                    mem_reg[i] <= `RANGE_DEFAULT;
                end else begin
                    mem_reg[i] <= 16'h0000;
                end
            end
        end else if (pif.we) begin
            mem_reg[pif.waddr] <= pif.wdata;
        end
    end

    // read data held until the next read
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pif.rdata <= 16'h0000;
        end else if (pif.re) begin
            pif.rdata <= mem_reg[pif.raddr];
        end
    end
endmodule : param_store
`default_nettype wire

// file: heat_status.sv
// heat_status: status word, actual value and error image of a sealing
// temperature controller, with set point clamp and parameter access.
// assumes all inputs come from logic on mclk_i; host requests arrive
// already decoded from the fieldbus output image.
// Operation
// - set point above the selected range ceiling is clamped to 300 or 500
// - calibration-running flag follows the calibration in progress
// - calibration-blocked flag while heating requested, element still cooling or reset requested
// - alarm flag holds from trigger until cleared by reset request
// - warning may join alarm; warning keeps alarm relay inactive
// - reached flag above 95 percent of set point, cleared on heat drop or alarm
// - in-band flag held clear when mode is off
// - follow mode: in-band flag tracks tolerance band membership
// - follow mode evaluates the band regardless of control mode
// - latch mode: heat request starts cycle, first band entry sets flag
// - latch mode: leaving band while heat requested clears flag
// - latch mode: flag held after heat drop until next cycle
// - separate low and high band limits, each up to 99 K
// - control-active flag only after heat request accepted and control entered
// - reserved info flag always reads zero
// - standby flag acknowledges reset or measurement-pause request
// - measurement-gap flag while regulating without measurement
// - actual value word is 16-bit signed, 1 degree per count
// - actual value forced to zero during calibration or fault
// - error code in bits 0 to 9 of the error word
// - parameter writes accepted only for attribute 1; reads always allowed
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "heat_status_params.svh"
module heat_status #(
    parameter int PAR_DEPTH = 16,
    parameter int PAR_AW    = 4
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // host requests
    input  wire logic        heat_request_i,
    input  wire logic        fault_reset_request_i,
    input  wire logic        measure_pause_request_i,
    // controller core
    input  wire logic [15:0] actual_temp_i,
    input  wire logic        measuring_i,
    input  wire logic        cal_running_i,
    input  wire logic        cooling_i,
    input  wire logic        fault_event_i,
    input  wire logic        fault_warning_i,
    input  wire logic [9:0]  error_code_i,
    // images and pins
    output logic      [15:0] setpoint_o,
    output logic      [15:0] status_word_o,
    output logic      [15:0] actual_word_o,
    output logic      [15:0] error_word_o,
    output logic             alarm_relay_o
);
    logic [15:0] sp_req_reg;
    logic        range_high_reg;
    logic [1:0]  ok_mode_reg;
    logic [15:0] tol_low_reg;
    logic [15:0] tol_high_reg;
    logic [15:0] setpoint_reg;
    logic        cal_running_flag;
    logic        cal_blocked_flag;
    logic        alarm_flag;
    logic        warning_flag;
    logic        temp_reached_flag;
    logic        temp_in_band_flag;
    logic        control_active_flag;
    logic        standby_ack_flag;
    logic        measure_gap_flag;
    logic        heat_d_reg;
    logic        reject_reg;
    logic [15:0] actual_reg;
    logic [15:0] error_reg;
    logic [31:0] rdata_reg;
    heat_status_pkg::latch_state_t latch_reg;
    logic [15:0] ceiling;
    logic        band_hit;
    logic        par_set;
    logic        par_ok;
    logic [7:0]  par_inst;
    logic [15:0] par_val;
    param_if #(.AW(PAR_AW)) pif ();
    param_store #(.DEPTH(PAR_DEPTH), .AW(PAR_AW)) u_store (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .pif      (pif)
    );
    // band test widened so set point minus limit cannot wrap
    function automatic logic in_band(input logic [15:0] act, input logic [15:0] sp,
                                     input logic [15:0] lo, input logic [15:0] hi);
        logic signed [17:0] a;
        logic signed [17:0] s;
        a = {{2{act[15]}}, act};
        s = {2'h0, sp};
        return (a >= s - $signed({2'h0, lo})) && (a <= s + $signed({2'h0, hi}));
    endfunction : in_band
    // compare as act*100 > sp*95, no divider needed
    function automatic logic above_pct(input logic [15:0] act, input logic [15:0] sp);
        logic signed [25:0] a;
        logic signed [25:0] s;
        a = {{10{act[15]}}, act};
        s = {10'h000, sp};
        return a * `TE_SCALE > s * `TE_THRESH;
    endfunction : above_pct
    // tolerance limits saturate rather than wrap
    function automatic logic [15:0] tol_clamp(input logic [15:0] v);
        return (v > `TOL_MAX) ? `TOL_MAX : v;
    endfunction : tol_clamp
    assign ceiling  = range_high_reg ? `SP_MAX_HIGH : `SP_MAX_LOW;
    assign band_hit = in_band(actual_temp_i, setpoint_reg, tol_low_reg, tol_high_reg);
    // parameter command decode
    assign par_set  = wr_i && (addr_i == `OFF_PARAM_SET);
    assign par_inst = wdata_i[`PAR_INST_HI:`PAR_INST_LO];
    assign par_val  = wdata_i[15:0];
    // attribute 1 only, existing instance only
    assign par_ok   = (wdata_i[`PAR_ATTR_HI:`PAR_ATTR_LO] == `PAR_ATTR_VALUE)
                      && (par_inst != 8'h00) && (32'(par_inst) < PAR_DEPTH);
    assign pif.we    = par_set && par_ok;
    assign pif.waddr = par_inst[PAR_AW-1:0];
    assign pif.wdata = (par_inst == `PAR_INST_TOL_LO || par_inst == `PAR_INST_TOL_HI) ? tol_clamp(par_val) : par_val;
    assign pif.re    = wr_i && (addr_i == `OFF_PARAM_GET);
    assign pif.raddr = wdata_i[`PAR_INST_LO+PAR_AW-1:`PAR_INST_LO];
    // software configuration; range and mode steer the flag logic
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sp_req_reg     <= 16'h0000;
            range_high_reg <= 1'b0;
            ok_mode_reg    <= `OK_MODE_FOLLOW;
        end else if (wr_i && addr_i == `OFF_SETPOINT) begin
            sp_req_reg <= wdata_i[15:0];
        end else if (wr_i && addr_i == `OFF_CONFIG) begin
            range_high_reg <= wdata_i[`CFG_RANGE_BIT];
            ok_mode_reg    <= wdata_i[`CFG_MODE_HI:`CFG_MODE_LO];
        end
    end
    // tolerance mirror of parameter instances 2 and 3
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tol_low_reg  <= `TOL_DEFAULT;
            tol_high_reg <= `TOL_DEFAULT;
            reject_reg   <= 1'b0;
        end else if (par_set) begin
            reject_reg <= !par_ok;
            if (par_ok && par_inst == `PAR_INST_TOL_LO) begin
                tol_low_reg <= tol_clamp(par_val);
            end
            if (par_ok && par_inst == `PAR_INST_TOL_HI) begin
                tol_high_reg <= tol_clamp(par_val);
            end
        end
    end
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            setpoint_reg <= 16'h0000;
        end else begin
            setpoint_reg <= (sp_req_reg > ceiling) ? ceiling : sp_req_reg;
        end
    end
    // alarm sticky; a new fault beats the reset clear
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alarm_flag   <= 1'b0;
            warning_flag <= 1'b0;
        end else if (fault_event_i) begin
            alarm_flag   <= 1'b1;
            warning_flag <= fault_warning_i;
        end else if (fault_reset_request_i) begin
            alarm_flag   <= 1'b0;
            warning_flag <= 1'b0;
        end
    end
    // calibration and handshake flags
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cal_running_flag <= 1'b0;
            cal_blocked_flag <= 1'b0;
            standby_ack_flag <= 1'b0;
            heat_d_reg       <= 1'b0;
        end else begin
            cal_running_flag <= cal_running_i;
            cal_blocked_flag <= heat_request_i || cooling_i || fault_reset_request_i;
            // acknowledge reset or pause; host keeps it until seen
            standby_ack_flag <= fault_reset_request_i || measure_pause_request_i;
            heat_d_reg       <= heat_request_i;
        end
    end
    // control mode and reached flag
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            control_active_flag <= 1'b0;
            temp_reached_flag   <= 1'b0;
        end else if (!heat_request_i || alarm_flag) begin
            // cleared on heat drop or alarm
            control_active_flag <= 1'b0;
            temp_reached_flag   <= 1'b0;
        end else begin
            if (!cal_running_i && !fault_reset_request_i) begin
                control_active_flag <= 1'b1;
            end
            if (control_active_flag && above_pct(actual_temp_i, setpoint_reg)) begin
                temp_reached_flag <= 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            measure_gap_flag <= 1'b0;
        end else begin
            measure_gap_flag <= heat_request_i && control_active_flag && !measuring_i;
        end
    end
    // temperature-ok flag in its three modes
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_in_band_flag <= 1'b0;
            latch_reg         <= heat_status_pkg::LATCH_IDLE;
        end else if (ok_mode_reg == `OK_MODE_OFF) begin
            temp_in_band_flag <= 1'b0;
            latch_reg         <= heat_status_pkg::LATCH_IDLE;
        end else if (ok_mode_reg == `OK_MODE_FOLLOW) begin
            temp_in_band_flag <= band_hit;
            latch_reg         <= heat_status_pkg::LATCH_IDLE;
        end else if (heat_request_i && !heat_d_reg) begin
            // new cycle starts cleared; entry counts from next edge
            temp_in_band_flag <= 1'b0;
            latch_reg         <= heat_status_pkg::LATCH_WAIT;
        end else begin
            unique case (latch_reg)
                heat_status_pkg::LATCH_IDLE: begin
                end
                heat_status_pkg::LATCH_WAIT: begin
                    if (heat_request_i && band_hit) begin
                        temp_in_band_flag <= 1'b1;
                        latch_reg         <= heat_status_pkg::LATCH_IN;
                    end
                end
                heat_status_pkg::LATCH_IN: begin
                    // leaving band clears; else held after drop
                    if (heat_request_i && !band_hit) begin
                        temp_in_band_flag <= 1'b0;
                        latch_reg         <= heat_status_pkg::LATCH_OUT;
                    end
                end
                heat_status_pkg::LATCH_OUT: begin
                end
            endcase
        end
    end
    // zero in calibration or fault; pause holds last value
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            actual_reg <= 16'h0000;
            error_reg  <= 16'h0000;
        end else begin
            error_reg <= {6'h00, error_code_i};
            if (cal_running_i || alarm_flag) begin
                actual_reg <= 16'h0000;
            end else if (!measure_pause_request_i && !fault_reset_request_i) begin
                actual_reg <= actual_temp_i;
            end
        end
    end
    // status image from flags; info bit wired low
    always_comb begin
        status_word_o                = 16'h0000;
        status_word_o[`ST_CAL_RUN]   = cal_running_flag;
        status_word_o[`ST_CAL_BLOCK] = cal_blocked_flag;
        status_word_o[`ST_ALARM]     = alarm_flag;
        status_word_o[`ST_WARN]      = warning_flag;
        status_word_o[`ST_REACHED]   = temp_reached_flag;
        status_word_o[`ST_IN_BAND]   = temp_in_band_flag;
        status_word_o[`ST_CTRL_ACT]  = control_active_flag;
        status_word_o[`ST_INFO]      = 1'b0;
        status_word_o[`ST_STANDBY]   = standby_ack_flag;
        status_word_o[`ST_GAP]       = measure_gap_flag;
    end
    assign alarm_relay_o = alarm_flag && !warning_flag;
    assign setpoint_o    = setpoint_reg;
    assign actual_word_o = actual_reg;
    assign error_word_o  = error_reg;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (!rd_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            unique case (addr_i)
                `OFF_SETPOINT:   rdata_reg <= {16'h0000, sp_req_reg};
                `OFF_CONFIG:     rdata_reg <= {29'h0, ok_mode_reg, range_high_reg};
                `OFF_STATUS:     rdata_reg <= {16'h0000, status_word_o};
                `OFF_ACTUAL:     rdata_reg <= {16'h0000, actual_reg};
                `OFF_ERROR:      rdata_reg <= {16'h0000, error_reg};
                `OFF_PARAM_DATA: rdata_reg <= {15'h0, reject_reg, pif.rdata};
                default:         rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign rdata_o = rdata_reg;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    AST_CLAMP: assert property (sp_req_reg > ceiling |=> setpoint_o == $past(ceiling))
        else $error("set point not clamped");
    AST_CAL_RUN: assert property (cal_running_i |=> status_word_o[`ST_CAL_RUN])
        else $error("calibration flag missing");
    AST_CAL_BLOCK: assert property (heat_request_i |=> status_word_o[`ST_CAL_BLOCK])
        else $error("calibration not blocked");
    AST_ALARM_HOLD: assert property (alarm_flag && !fault_reset_request_i |=> alarm_flag)
        else $error("alarm dropped without reset");
    AST_RELAY: assert property (warning_flag |-> !alarm_relay_o)
        else $error("relay active on warning");
    AST_TE_DROP: assert property (!heat_request_i |=> !temp_reached_flag)
        else $error("reached flag kept after heat drop");
    AST_OK_OFF: assert property (ok_mode_reg == `OK_MODE_OFF |=> !temp_in_band_flag)
        else $error("in-band flag set while off");
    AST_FOLLOW: assert property (ok_mode_reg == `OK_MODE_FOLLOW && $stable(ok_mode_reg)
                                 |=> temp_in_band_flag == $past(band_hit))
        else $error("follow mode mismatch");
    AST_LATCH_HOLD: assert property (ok_mode_reg == `OK_MODE_LATCH && temp_in_band_flag
                                     && !heat_request_i ##1 !heat_request_i
                                     && ok_mode_reg == `OK_MODE_LATCH |-> temp_in_band_flag)
        else $error("latched flag lost");
    AST_CTRL: assert property (control_active_flag |-> $past(heat_request_i))
        else $error("control active without request");
    AST_STANDBY: assert property (fault_reset_request_i |=> status_word_o[`ST_STANDBY])
        else $error("standby not acknowledged");
    AST_ACT_ZERO: assert property (cal_running_i |=> actual_word_o == 16'h0000)
        else $error("actual value not zero");
    AST_PAR_REJ: assert property (par_set && !par_ok |=> reject_reg ##1 1'b1)
        else $error("bad attribute write not rejected");

    COV_LATCH: cover property (latch_reg == heat_status_pkg::LATCH_IN ##1
                               latch_reg == heat_status_pkg::LATCH_OUT);
    COV_REACHED: cover property (temp_reached_flag);
    COV_WARN: cover property (alarm_flag && warning_flag);
    COV_PAR_SET: cover property (pif.we);
endmodule : heat_status
`default_nettype wire

// file: plc_host.sv
// plc_host: scanner side model raising heat, reset and pause requests
// assumes the standby flag is taken from the status word on mclk_i
`timescale 1ns/1ns
`default_nettype none
module plc_host (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    // bench wishes and device answer
    input  wire logic want_heat_i,
    input  wire logic want_reset_i,
    input  wire logic want_pause_i,
    input  wire logic standby_i,
    // request bits
    output logic      heat_request_o,
    output logic      fault_reset_request_o,
    output logic      measure_pause_request_o
);
    // heat request follows the wish one edge later
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) heat_request_o <= 1'b0;
        else heat_request_o <= want_heat_i;
    end
    // release only after standby
    // a request dropped early would be lost by the device
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_reset_request_o   <= 1'b0;
            measure_pause_request_o <= 1'b0;
        end else begin
            if (want_reset_i) fault_reset_request_o <= 1'b1;
            else if (standby_i) fault_reset_request_o <= 1'b0;
            if (want_pause_i) measure_pause_request_o <= 1'b1;
            else if (standby_i) measure_pause_request_o <= 1'b0;
        end
    end
endmodule : plc_host
`default_nettype wire

// file: testbench.sv
// testbench: register and request sequences against the heat status block
// assumes the host model drives the request bits; bench drives core inputs
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    logic mclk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic wh = 1'b0, wrs = 1'b0, wp = 1'b0, heat, rst, pause;
    logic [15:0] actual_temp_i = 16'h0050, setpoint_o, status_word_o, actual_word_o, error_word_o;
    logic measuring_i = 1'b1, cal_running_i = 1'b0, cooling_i = 1'b0, relay;
    logic fault_event_i = 1'b0, fault_warning_i = 1'b0;
    logic [9:0] error_code_i = 10'h000;
    int num_errors = 0, check_count = 0;
    // 10 MHz clock
    always #50 mclk_i = ~mclk_i;
    heat_status u_heat_status (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .heat_request_i(heat), .fault_reset_request_i(rst),
        .measure_pause_request_i(pause), .actual_temp_i(actual_temp_i), .measuring_i(measuring_i),
        .cal_running_i(cal_running_i), .cooling_i(cooling_i), .fault_event_i(fault_event_i),
        .fault_warning_i(fault_warning_i), .error_code_i(error_code_i), .setpoint_o(setpoint_o),
        .status_word_o(status_word_o), .actual_word_o(actual_word_o), .error_word_o(error_word_o),
        .alarm_relay_o(relay));
    plc_host u_plc_host (.mclk_i(mclk_i), .resetn_i(resetn_i), .want_heat_i(wh), .want_reset_i(wrs),
        .want_pause_i(wp), .standby_i(status_word_o[8]), .heat_request_o(heat),
        .fault_reset_request_o(rst), .measure_pause_request_o(pause));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        `CHK(rdata_o, e)
    endtask : rd
    // host model plus flag latency fit well inside four edges
    task automatic settle;
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : settle
    task automatic st(input int b, input logic e);
        settle();
        `CHK(status_word_o[b], e)
    endtask : st
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // watchdog well above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rd(8'h04, 32'h2);
        rd(8'h20, 32'h0);
        wr(8'h00, 32'h3E8);
        rd(8'h00, 32'h000003E8);
        settle();
        `CHK(setpoint_o, 16'h012C)
        wr(8'h04, 32'h3);
        settle();
        `CHK(setpoint_o, 16'h01F4)
        wr(8'h04, 32'h2);
        wr(8'h00, 32'hC8);
        $display("test clamp done");
        @(posedge mclk_i) cal_running_i <= 1'b1;
        st(0, 1'b1);
        `CHK(actual_word_o, 16'h0000)
        @(posedge mclk_i) cal_running_i <= 1'b0;
        @(posedge mclk_i) cooling_i <= 1'b1;
        st(1, 1'b1);
        @(posedge mclk_i) cooling_i <= 1'b0;
        st(1, 1'b0);
        `CHK(status_word_o[0], 1'b0)
        $display("test calibration done");
        @(posedge mclk_i) actual_temp_i <= 16'h00BF;
        @(posedge mclk_i) wh <= 1'b1;
        st(6, 1'b1);
        st(4, 1'b1);
        `CHK(status_word_o[7], 1'b0)
        `CHK(actual_word_o, 16'h00BF)
        @(posedge mclk_i) measuring_i <= 1'b0;
        st(9, 1'b1);
        @(posedge mclk_i) measuring_i <= 1'b1;
        st(9, 1'b0);
        @(posedge mclk_i) wh <= 1'b0;
        st(4, 1'b0);
        `CHK(status_word_o[6], 1'b0)
        @(posedge mclk_i) actual_temp_i <= 16'hFFF6;
        settle();
        `CHK(actual_word_o, 16'hFFF6)
        $display("test control done");
        wr(8'h14, 32'h02010014);
        wr(8'h14, 32'h03010070);
        wr(8'h14, 32'h02020005);
        wr(8'h18, 32'h02000000);
        rd(8'h1C, 32'h00010014);
        wr(8'h18, 32'h03000000);
        rd(8'h1C, 32'h00010063);
        @(posedge mclk_i) actual_temp_i <= 16'h00B4;
        st(5, 1'b1);
        @(posedge mclk_i) actual_temp_i <= 16'h00B3;
        st(5, 1'b0);
        @(posedge mclk_i) actual_temp_i <= 16'h012B;
        st(5, 1'b1);
        @(posedge mclk_i) actual_temp_i <= 16'h012C;
        st(5, 1'b0);
        wr(8'h04, 32'h0);
        @(posedge mclk_i) actual_temp_i <= 16'h00C8;
        st(5, 1'b0);
        $display("test band done");
        wr(8'h04, 32'h4);
        @(posedge mclk_i) actual_temp_i <= 16'h0064;
        @(posedge mclk_i) wh <= 1'b1;
        st(5, 1'b0);
        @(posedge mclk_i) actual_temp_i <= 16'h00C8;
        st(5, 1'b1);
        @(posedge mclk_i) wh <= 1'b0;
        st(5, 1'b1);
        @(posedge mclk_i) actual_temp_i <= 16'h0064;
        st(5, 1'b1);
        @(posedge mclk_i) wh <= 1'b1;
        st(5, 1'b0);
        @(posedge mclk_i) actual_temp_i <= 16'h00C8;
        st(5, 1'b1);
        @(posedge mclk_i) actual_temp_i <= 16'h0064;
        st(5, 1'b0);
        @(posedge mclk_i) wh <= 1'b0;
        $display("test latch done");
        wr(8'h04, 32'h2);
        @(posedge mclk_i) error_code_i <= 10'h2A5;
        for (int w = 0; w < 2; w++) begin
            @(posedge mclk_i) fault_event_i <= 1'b1;
            fault_warning_i <= w[0];
            @(posedge mclk_i) fault_event_i <= 1'b0;
            st(2, 1'b1);
            `CHK(status_word_o[3], w[0])
            `CHK(relay, !w[0])
            `CHK(actual_word_o, 16'h0000)
            `CHK(error_word_o, 16'h02A5)
            rd(8'h10, 32'h000002A5);
            rd(8'h0C, 32'h00000000);
            rd(8'h08, {28'h0000000, w[0], 3'h4});
            @(posedge mclk_i) wrs <= 1'b1;
            st(8, 1'b1);
            @(posedge mclk_i) wrs <= 1'b0;
            st(2, 1'b0);
        end
        $display("test alarm done");
        @(posedge mclk_i) actual_temp_i <= 16'h0096;
        @(posedge mclk_i) wp <= 1'b1;
        settle();
        @(posedge mclk_i) actual_temp_i <= 16'h00AA;
        st(8, 1'b1);
        `CHK(actual_word_o, 16'h0096)
        @(posedge mclk_i) wp <= 1'b0;
        settle();
        $display("test pause done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
